// file: cwd_top.sv
`timescale 1ns/1ns
// What this block does
// - expected response comes from LFSR step
// - key readable anytime without timing effect
// - valid refresh ends open, starts closed
// - reset output assertion restarts watchdog
// - after reset release, long first open window
// - simple mode: any key value refreshes in open window
// - wrong response discarded, wrong-response violation
// - correct open-window response refreshes, advances key
// - correct closed-window response gives early violation
// - open window lapse gives expiry violation
// - violation asserts reset, restart after release
// - violation counter cleared only at power-on
// - watchdog runs when enabled and reset released
// - watchdog config writes except lock bit refused while lock set
// - enable starts primary, then sequencer when good
// - slot spacing is one of four intervals
// - enable low turns everything off
// - reinit event restarts slots when map clear
// - reset held for hold time after regulation
// - two-bit field picks hold timeout
module cwd_top
  import cwd_pkg::*;
#(
  parameter int unsigned TICK_CYC    = TICK_CYC_DEF,
  parameter logic [7:0]  LFSR_TAPS   = LFSR_TAPS_DEF,
  parameter logic [7:0]  LFSR_SEED   = LFSR_SEED_DEF,
  parameter logic [15:0] CLOSED_BASE = CLOSED_BASE_DEF,
  parameter logic [15:0] OPEN_BASE   = OPEN_BASE_DEF,
  parameter logic [15:0] FIRST_OPEN  = FIRST_OPEN_DEF,
  parameter logic [1:0]  SLOT_SEL    = 2'h0
) (
  // clock and reset
  input  logic              core_clk,
  input  logic              rst_n,
  // register port
  input  logic [ADDR_W-1:0] reg_addr,
  input  logic [DATA_W-1:0] reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // pins from outside
  input  logic              en_pin,
  input  logic              primary_good_pin,
  input  logic              por_event_pin,
  input  logic [5:0]        mon_fault_pin,
  // output enables
  output logic              primary_en,
  output logic [2:0]        out_en,
  // open-drain reset pin
  output logic              reset_o,
  output logic              reset_oe
);

  localparam int unsigned NSYNC  = 9;
  localparam int unsigned TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam int unsigned WIN_W  = 20;

  generate
    if (TICK_CYC < 2 || CLOSED_BASE == 16'h0000 || OPEN_BASE == 16'h0000
        || FIRST_OPEN == 16'h0000 || LFSR_SEED == 8'h00) begin : g_bad
      $error("cwd_top: tick, window bases and seed must be nonzero");
    end
  endgenerate

  // ---------------- pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  assign pin_raw = {mon_fault_pin, por_event_pin, primary_good_pin, en_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] ff_r;
      logic       st_r;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          ff_r <= 3'h0;
          st_r <= 1'b0;
        end else begin
          ff_r <= {ff_r[1:0], pin_raw[gi]};
          if (ff_r[1] == ff_r[2]) begin
            st_r <= ff_r[2];
          end
        end
      end
      assign pin_s[gi] = st_r;
    end
  endgenerate

  logic       en_s;
  logic       primary_good_s;
  logic       por_event_s;
  logic [5:0] mon_fault_s;
  assign en_s           = pin_s[0];
  assign primary_good_s = pin_s[1];
  assign por_event_s    = pin_s[2];
  assign mon_fault_s    = pin_s[8:3];

  // ---------------- base tick
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // ---------------- decode
  logic wr_key;
  logic wr_wdcfg;
  logic wr_wdstat;
  logic wr_seqcfg;
  assign wr_key    = reg_wr && (reg_addr == OFS_KEY);
  assign wr_wdcfg  = reg_wr && (reg_addr == OFS_WDCFG);
  assign wr_wdstat = reg_wr && (reg_addr == OFS_WDSTAT);
  assign wr_seqcfg = reg_wr && (reg_addr == OFS_SEQCFG);

  // ---------------- watchdog configuration
  logic       cfg_run_r;
  logic       cfg_lock_r;
  logic       cfg_simple_r;
  logic [3:0] cfg_closed_r;
  logic [3:0] cfg_open_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_run_r    <= RST_RUN;
      cfg_lock_r   <= RST_LOCK;
      cfg_simple_r <= RST_SIMPLE;
      cfg_closed_r <= RST_CLOSED;
      cfg_open_r   <= RST_OPEN;
    end else if (wr_wdcfg) begin
      cfg_lock_r <= reg_wdata[F_LOCK];
      if (!cfg_lock_r) begin
        cfg_run_r    <= reg_wdata[F_RUN];
        cfg_simple_r <= reg_wdata[F_SIMPLE];
        cfg_closed_r <= reg_wdata[F_CLOSED +: 4];
        cfg_open_r   <= reg_wdata[F_OPEN +: 4];
      end
    end
  end

  // ---------------- sequencer configuration
  logic [1:0] hold_sel_r;
  logic [5:0] slot_field_r;
  logic [5:0] map_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_sel_r   <= RST_HOLD;
      slot_field_r <= RST_SLOT;
      map_r        <= RST_MAP;
    end else if (wr_seqcfg) begin
      hold_sel_r   <= reg_wdata[F_HOLD +: 2];
      slot_field_r <= reg_wdata[F_SLOT +: 6];
      map_r        <= reg_wdata[F_MAP +: 6];
    end
  end

  // ---------------- challenge key
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  logic       resp_ok;

  // next LFSR state is the answer
  assign key_nxt = {key_r[6:0], ^(key_r & LFSR_TAPS)};
  assign resp_ok = (reg_wdata[7:0] == key_nxt);

  // ---------------- watchdog window machine
  cwd_wd_t          wd_state_r;
  logic [WIN_W-1:0] win_cnt_r;
  logic [WIN_W-1:0] closed_len;
  logic [WIN_W-1:0] open_len;
  logic             rst_asserted_r;
  logic             wd_active;
  logic             refresh;
  logic             viol_wrong;
  logic             viol_early;
  logic             viol_exp;
  logic             any_viol;

  // window lengths scale the base parameters
  assign closed_len = WIN_W'(CLOSED_BASE) * (WIN_W'(cfg_closed_r) + 20'h00001);
  assign open_len   = WIN_W'(OPEN_BASE) * (WIN_W'(cfg_open_r) + 20'h00001);
  assign wd_active  = cfg_run_r && !rst_asserted_r;
  assign any_viol   = viol_wrong || viol_early || viol_exp;

  always_comb begin
    refresh    = 1'b0;
    viol_wrong = 1'b0;
    viol_early = 1'b0;
    viol_exp   = 1'b0;
    if (wr_key && wd_state_r != WD_IDLE) begin
      if (!cfg_simple_r && !resp_ok) begin
        viol_wrong = 1'b1;
      end else if (wd_state_r == WD_CLOSED) begin
        viol_early = 1'b1;
      end else begin
        refresh = 1'b1;
      end
    end else if (wd_state_r == WD_OPEN && tick_r && win_cnt_r == '0) begin
      viol_exp = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wd_state_r <= WD_IDLE;
      win_cnt_r  <= '0;
    end else if (!wd_active || any_viol) begin
      wd_state_r <= WD_IDLE;
      win_cnt_r  <= '0;
    end else begin
      unique case (wd_state_r)
        WD_IDLE: begin
          wd_state_r <= WD_OPEN;
          win_cnt_r  <= WIN_W'(FIRST_OPEN);
        end
        WD_CLOSED: begin
          if (tick_r) begin
            if (win_cnt_r == '0) begin
              wd_state_r <= WD_OPEN;
              win_cnt_r  <= open_len;
            end else begin
              win_cnt_r <= win_cnt_r - 1'b1;
            end
          end
        end
        WD_OPEN: begin
          if (refresh) begin
            wd_state_r <= WD_CLOSED;
            win_cnt_r  <= closed_len;
          end else if (tick_r) begin
            win_cnt_r <= win_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      key_r <= LFSR_SEED;
    end else if (refresh && !cfg_simple_r) begin
      key_r <= key_nxt;
    end
  end

  // ---------------- violation record
  logic [2:0] viol_flags_r;
  logic [7:0] viol_count_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      viol_flags_r <= 3'h0;
    end else begin
      viol_flags_r <= (viol_flags_r & ~(wr_wdstat ? reg_wdata[F_VIOL +: 3] : 3'h0))
                      | {viol_early, viol_exp, viol_wrong};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      viol_count_r <= 8'h00;
    end else if (any_viol && viol_count_r != 8'hFF) begin
      viol_count_r <= viol_count_r + 1'b1;
    end
  end

  // ---------------- power-up sequencer
  cwd_seq_t    seq_state_r;
  logic [1:0]  slot_idx_r;
  logic [15:0] slot_cnt_r;
  logic [15:0] slot_len;
  logic        por_event_d_r;
  logic        reinit;

  always_comb begin
    unique case (SLOT_SEL)
      2'h0: slot_len = SLOT0_TICKS;
      2'h1: slot_len = SLOT1_TICKS;
      2'h2: slot_len = SLOT2_TICKS;
      2'h3: slot_len = SLOT3_TICKS;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      por_event_d_r <= 1'b0;
    end else begin
      por_event_d_r <= por_event_s;
    end
  end

  assign reinit = por_event_s && !por_event_d_r && (map_r == 6'h00);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_state_r <= SQ_OFF;
      slot_idx_r  <= 2'h0;
      slot_cnt_r  <= 16'h0000;
    end else if (!en_s) begin
      seq_state_r <= SQ_OFF;
      slot_idx_r  <= 2'h0;
      slot_cnt_r  <= 16'h0000;
    end else if (reinit) begin
      seq_state_r <= SQ_PRIMARY;
      slot_idx_r  <= 2'h0;
      slot_cnt_r  <= 16'h0000;
    end else begin
      unique case (seq_state_r)
        SQ_OFF: begin
          seq_state_r <= SQ_PRIMARY;
        end
        SQ_PRIMARY: begin
          if (primary_good_s) begin
            seq_state_r <= SQ_SLOTS;
            slot_idx_r  <= 2'h0;
            slot_cnt_r  <= slot_len;
          end
        end
        SQ_SLOTS: begin
          if (tick_r) begin
            if (slot_cnt_r != 16'h0000) begin
              slot_cnt_r <= slot_cnt_r - 1'b1;
            end else if (slot_idx_r == 2'h3) begin
              seq_state_r <= SQ_ON;
            end else begin
              slot_idx_r <= slot_idx_r + 1'b1;
              slot_cnt_r <= slot_len;
            end
          end
        end
        SQ_ON: begin
          seq_state_r <= SQ_ON;
        end
      endcase
    end
  end

  // ---------------- reset output control
  logic [15:0] hold_cnt_r;
  logic [15:0] hold_len;
  logic        power_ok;

  always_comb begin
    unique case (hold_sel_r)
      2'h0: hold_len = HOLD0_TICKS;
      2'h1: hold_len = HOLD1_TICKS;
      2'h2: hold_len = HOLD2_TICKS;
      2'h3: hold_len = HOLD3_TICKS;
    endcase
  end

  assign power_ok = (seq_state_r == SQ_ON) && primary_good_s && !(|(mon_fault_s & map_r));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_asserted_r <= 1'b1;
      hold_cnt_r     <= HOLD0_TICKS;
    end else if (any_viol || !power_ok) begin
      rst_asserted_r <= 1'b1;
      hold_cnt_r     <= hold_len;
    end else if (rst_asserted_r && tick_r) begin
      if (hold_cnt_r == 16'h0000) begin
        rst_asserted_r <= 1'b0;
      end else begin
        hold_cnt_r <= hold_cnt_r - 1'b1;
      end
    end
  end

  // ---------------- output flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_en <= 1'b0;
      out_en     <= 3'h0;
      reset_o    <= 1'b0;
      reset_oe   <= 1'b1;
    end else begin
      primary_en <= (seq_state_r != SQ_OFF);
      for (int k = 0; k < 3; k++) begin
        out_en[k] <= (seq_state_r == SQ_ON)
                     || (seq_state_r == SQ_SLOTS && slot_idx_r >= slot_field_r[2*k +: 2]);
      end
      reset_o  <= 1'b0;
      reset_oe <= rst_asserted_r;
    end
  end

  // ---------------- read port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_KEY:     reg_rdata <= {24'h000000, key_r};
        OFS_WDCFG:   reg_rdata <= {20'h00000, cfg_open_r, cfg_closed_r, 1'b0,
                                   cfg_simple_r, cfg_lock_r, cfg_run_r};
        OFS_WDSTAT:  reg_rdata <= {13'h0000, wd_state_r, rst_asserted_r,
                                   viol_count_r, 5'h00, viol_flags_r};
        OFS_SEQCFG:  reg_rdata <= {18'h00000, map_r, slot_field_r, hold_sel_r};
        OFS_SEQSTAT: reg_rdata <= {26'h0000000, power_ok, seq_state_r == SQ_ON,
                                   primary_en, out_en};
        default:     reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// file: cwd_pkg.sv
package cwd_pkg;

  // clock and base tick
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_US       = 100;
  localparam int unsigned TICK_CYC_DEF  = TICK_US * 1000 / CLK_PERIOD_NS;

  // power-up slot spacing, factory choice
  localparam int unsigned SLOT0_US = 2500;
  localparam int unsigned SLOT1_US = 4900;
  localparam int unsigned SLOT2_US = 9800;
  localparam int unsigned SLOT3_US = 19500;
  localparam logic [15:0] SLOT0_TICKS = 16'(SLOT0_US / TICK_US);
  localparam logic [15:0] SLOT1_TICKS = 16'(SLOT1_US / TICK_US);
  localparam logic [15:0] SLOT2_TICKS = 16'(SLOT2_US / TICK_US);
  localparam logic [15:0] SLOT3_TICKS = 16'(SLOT3_US / TICK_US);

  // reset hold timeout choices
  localparam int unsigned HOLD0_US = 9800;
  localparam int unsigned HOLD1_US = 19500;
  localparam int unsigned HOLD2_US = 29300;
  localparam int unsigned HOLD3_US = 39000;
  localparam logic [15:0] HOLD0_TICKS = 16'(HOLD0_US / TICK_US);
  localparam logic [15:0] HOLD1_TICKS = 16'(HOLD1_US / TICK_US);
  localparam logic [15:0] HOLD2_TICKS = 16'(HOLD2_US / TICK_US);
  localparam logic [15:0] HOLD3_TICKS = 16'(HOLD3_US / TICK_US);

  // watchdog defaults, window bases in ticks
  localparam logic [15:0] CLOSED_BASE_DEF = 16'h0064;
  localparam logic [15:0] OPEN_BASE_DEF   = 16'h0064;
  localparam logic [15:0] FIRST_OPEN_DEF  = 16'h07D0;
  localparam logic [7:0]  LFSR_TAPS_DEF   = 8'hB8;
  localparam logic [7:0]  LFSR_SEED_DEF   = 8'h5A;

  // register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_KEY     = 8'h00;
  localparam logic [7:0] OFS_WDCFG   = 8'h04;
  localparam logic [7:0] OFS_WDSTAT  = 8'h08;
  localparam logic [7:0] OFS_SEQCFG  = 8'h0C;
  localparam logic [7:0] OFS_SEQSTAT = 8'h10;

  // watchdog_divider_config fields
  localparam int unsigned F_RUN    = 0;
  localparam int unsigned F_LOCK   = 1;
  localparam int unsigned F_SIMPLE = 2;
  localparam int unsigned F_CLOSED = 4;
  localparam int unsigned F_OPEN   = 8;
  localparam logic       RST_RUN    = 1'b0;
  localparam logic       RST_LOCK   = 1'b0;
  localparam logic       RST_SIMPLE = 1'b0;
  localparam logic [3:0] RST_CLOSED = 4'h0;
  localparam logic [3:0] RST_OPEN   = 4'h0;

  // status fields
  localparam int unsigned F_VIOL  = 0;
  localparam int unsigned F_COUNT = 8;
  localparam int unsigned F_RSTA  = 16;
  localparam int unsigned F_WDST  = 17;

  // sequencer config fields
  localparam int unsigned F_HOLD = 0;
  localparam int unsigned F_SLOT = 2;
  localparam int unsigned F_MAP  = 8;
  localparam logic [1:0] RST_HOLD = 2'h0;
  localparam logic [5:0] RST_SLOT = 6'h24;
  localparam logic [5:0] RST_MAP  = 6'h3F;

  typedef enum logic [1:0] {WD_IDLE, WD_CLOSED, WD_OPEN} cwd_wd_t;
  typedef enum logic [1:0] {SQ_OFF, SQ_PRIMARY, SQ_SLOTS, SQ_ON} cwd_seq_t;

endpackage

// file: cwd_pwr_model.sv
`timescale 1ns/1ns
module cwd_pwr_model #(
  parameter int unsigned DLY = 20
) (
  // clock
  input  logic core_clk,
  // regulator control and status
  input  logic primary_en,
  output logic primary_good_pin
);
  int unsigned ramp_r;

  always_ff @(posedge core_clk) begin
    if (!primary_en) begin
      ramp_r           <= 0;
      primary_good_pin <= 1'b0;
    end else if (ramp_r < DLY) begin
      ramp_r <= ramp_r + 1;
    end else begin
      primary_good_pin <= 1'b1;
    end
  end
endmodule

// file: cwd_top_sva.sv
`timescale 1ns/1ns
module cwd_top_chk
  import cwd_pkg::*;
(
  // clock and reset
  input logic              core_clk,
  input logic              rst_n,
  // register port
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic              reg_wr,
  input logic              reg_rd,
  input logic [DATA_W-1:0] reg_rdata,
  // pins
  input logic              en_pin,
  input logic              primary_good_pin,
  input logic              por_event_pin,
  input logic [5:0]        mon_fault_pin,
  input logic              primary_en,
  input logic [2:0]        out_en,
  input logic              reset_o,
  input logic              reset_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside answer cycle");
  drive_low_a: assert property (reset_o == 1'b0)
    else $error("reset pin driven high");
  out_order_a: assert property (|out_en |-> primary_en)
    else $error("output on without primary");
  en_off_a: assert property (!en_pin [*8] |=> !primary_en && out_en == 3'h0)
    else $error("outputs stay on with enable low");
  primary_first_a: assert property ($rose(primary_en) |-> out_en == 3'h0 && $past(en_pin, 3))
    else $error("primary started out of order");
  slot_gap_a: assert property ($rose(out_en[1]) |-> $past(out_en[0], 8))
    else $error("slots too close");
  release_good_a: assert property ($fell(reset_oe) |-> primary_good_pin && primary_en)
    else $error("reset released without regulation");
  hold_min_a: assert property ($fell(reset_oe) |-> $past(reset_oe, 8))
    else $error("reset hold too short");
  guard_low_a: assert property (!primary_good_pin [*6] |-> reset_oe)
    else $error("reset released while primary bad");

  cover property ($fell(reset_oe));
  cover property ($rose(reset_oe) && primary_en);
  cover property ($rose(out_en[2]));
endmodule

bind cwd_top cwd_top_chk cwd_top_chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_pin(en_pin),
  .primary_good_pin(primary_good_pin), .por_event_pin(por_event_pin),
  .mon_fault_pin(mon_fault_pin), .primary_en(primary_en), .out_en(out_en),
  .reset_o(reset_o), .reset_oe(reset_oe)
);

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  import cwd_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        en_pin;
  logic        primary_good_pin;
  logic        por_event_pin;
  logic [5:0]  mon_fault_pin;
  logic        primary_en;
  logic [2:0]  out_en;
  logic        reset_o;
  logic        reset_oe;
  logic [31:0] d;
  logic [7:0]  k;
  int          error_cnt;
  int          checks_done;
  int          cyc;

  cwd_top #(.TICK_CYC(4), .CLOSED_BASE(16'h0004), .OPEN_BASE(16'h0004),
    .FIRST_OPEN(16'h0008)) cwd_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_pin(en_pin),
    .primary_good_pin(primary_good_pin), .por_event_pin(por_event_pin),
    .mon_fault_pin(mon_fault_pin), .primary_en(primary_en), .out_en(out_en),
    .reset_o(reset_o), .reset_oe(reset_oe));

  cwd_pwr_model #(.DLY(20)) cwd_pwr_model_i (
    .core_clk(core_clk), .primary_en(primary_en), .primary_good_pin(primary_good_pin));

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // bounded wait for the reset_oe level
  task wait_oe(input logic v, input int n);
    for (int i = 0; i < n && reset_oe !== v; i++) @(negedge core_clk);
    chk({31'h0, reset_oe}, {31'h0, v});
  endtask

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], ^(s & LFSR_TAPS_DEF)};
  endfunction

  task end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t ns: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    en_pin = 1'b0;
    por_event_pin = 1'b0;
    mon_fault_pin = 6'h00;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(OFS_WDCFG, 32'h0);
    rdchk(OFS_SEQCFG, 32'h0000_3F90);
    rdchk(OFS_WDSTAT, 32'h0001_0000);
    rdchk(8'h14, 32'h0);
    rdchk(OFS_KEY, {24'h0, LFSR_SEED_DEF});
    wr(OFS_WDCFG, 32'h2);
    wr(OFS_WDCFG, 32'h1);
    rdchk(OFS_WDCFG, 32'h0);
    wr(OFS_WDCFG, 32'h0);
    rdchk(OFS_WDCFG, 32'h0);
    $display("test reset_and_lock done");
    en_pin <= 1'b1;
    wait_oe(1'b0, 3000);
    chk({28'h0, primary_en, out_en}, 32'hF);
    rdchk(OFS_SEQSTAT, 32'h3F);
    $display("test power_up done");
    wr(OFS_WDCFG, 32'h1);
    rdchk(OFS_KEY, {24'h0, LFSR_SEED_DEF});
    k = nxt(LFSR_SEED_DEF);
    wr(OFS_KEY, {24'h0, k});
    rdchk(OFS_WDSTAT, 32'h0002_0000);
    rdchk(OFS_KEY, {24'h0, k});
    wr(OFS_KEY, {24'h0, nxt(k)});
    rdchk(OFS_WDSTAT, 32'h0001_0104);
    wait_oe(1'b0, 1500);
    rd(OFS_KEY, d);
    k = d[7:0];
    wr(OFS_KEY, {24'h0, ~nxt(k)});
    rdchk(OFS_WDSTAT, 32'h0001_0205);
    wait_oe(1'b0, 1500);
    repeat (60) @(posedge core_clk);
    rdchk(OFS_WDSTAT, 32'h0001_0307);
    wait_oe(1'b0, 1500);
    wr(OFS_WDSTAT, 32'h7);
    rdchk(OFS_WDSTAT, 32'h0004_0300);
    $display("test challenge_response done");
    wr(OFS_WDCFG, 32'h5);
    rd(OFS_KEY, d);
    wr(OFS_KEY, 32'hFFFF_FFFF);
    rdchk(OFS_WDSTAT, 32'h0002_0300);
    rdchk(OFS_KEY, d);
    wr(OFS_WDCFG, 32'h0);
    rdchk(OFS_WDSTAT, 32'h0000_0300);
    $display("test simple_window done");
    mon_fault_pin <= 6'h01;
    wait_oe(1'b1, 20);
    mon_fault_pin <= 6'h00;
    wait_oe(1'b0, 1500);
    $display("test mapped_fault done");
    wr(OFS_SEQCFG, 32'h0000_0090);
    por_event_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    por_event_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk({29'h0, out_en}, 32'h1);
    en_pin <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk({31'h0, primary_en}, 32'h0);
    $display("test reinit_and_off done");
    end_of_test();
  end
endmodule
